// file: rtl/iob_consts.svh
`ifndef IOB_CONSTS_SVH
`define IOB_CONSTS_SVH
`define IOB_DEV_NUM_W      8
`define IOB_DEFAULT_DEV    8'h22
`define IOB_ST_BUSY_BIT    3
`define IOB_ST_EXAM_BIT    2
`define IOB_ST_END_BIT     1
`define IOB_ST_UNAV_BIT    0
`define IOB_TIMEOUT_US     50
`define IOB_CLK_MHZ        100
`define IOB_TIMEOUT_CYC    (`IOB_TIMEOUT_US * `IOB_CLK_MHZ)
`define IOB_CLEAR_CYC      2'h3
`define IOB_REG_CTRL       5'h00
`define IOB_REG_DATA       5'h04
`define IOB_REG_STATUS     5'h08
`define IOB_REG_RESULT     5'h0C
`define IOB_REG_IRQ_STAT   5'h10
`define IOB_REG_IRQ_MASK   5'h14
`define IOB_CMD_SELECT     3'h1
`define IOB_CMD_READ       3'h2
`define IOB_CMD_WRITE      3'h3
`define IOB_CMD_STATUS     3'h4
`endif

// file: rtl/iob_pkg.sv
package iob_pkg;
	typedef enum logic [2:0] {
		IOB_OP_NONE   = 3'h0,
		IOB_OP_SELECT = 3'h1,
		IOB_OP_READ   = 3'h2,
		IOB_OP_WRITE  = 3'h3,
		IOB_OP_STATUS = 3'h4
	} iob_op_type;
endpackage

// file: rtl/iob_bus_if.sv
`timescale 1ns/100ps
interface iob_bus_if;
	logic [7:0] data_out_lines_n;
	logic [7:0] data_in_lines_n;
	logic       data_in_oe;
	logic       select_strobe;
	logic       read_request;
	logic       write_strobe;
	logic       status_request;
	logic       handshake_ack;
	logic       system_clear;
	modport chan (
		output data_out_lines_n,
		input  data_in_lines_n,
		input  data_in_oe,
		output select_strobe,
		output read_request,
		output write_strobe,
		output status_request,
		input  handshake_ack,
		output system_clear
	);
	modport ctrl (
		input  data_out_lines_n,
		output data_in_lines_n,
		output data_in_oe,
		input  select_strobe,
		input  read_request,
		input  write_strobe,
		input  status_request,
		output handshake_ack,
		input  system_clear
	);
endinterface

// file: rtl/iob_ctrl.sv
`timescale 1ns/100ps
`include "iob_consts.svh"

module iob_ctrl #(
	parameter logic [7:0] DEV_NUM = `IOB_DEFAULT_DEV
) (
	input  wire logic  aclk,
	input  wire logic  aresetn,
	iob_bus_if.ctrl    bus,
	input  wire logic [7:0] dev_read_byte,
	input  wire logic       dev_busy,
	input  wire logic       dev_examine,
	input  wire logic       dev_end_of_medium,
	input  wire logic       dev_unavailable,
	input  wire logic [3:0] dev_specific,
	output logic [7:0]      dev_write_byte,
	output logic            dev_write_pulse,
	output logic            selected
);
	// ************************************************************
	// Input synchronisers
	// ************************************************************
	// Bus lines come from another party, so three stages are used.
	logic [12:0] s1_reg, s2_reg, s3_reg;
	logic [12:0] stable_reg;
	wire  [12:0] raw_in = {bus.system_clear, bus.status_request, bus.write_strobe,
	                       bus.read_request, bus.select_strobe, bus.data_out_lines_n};
	wire  [12:0] agree  = ~(s2_reg ^ s3_reg);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg     <= 13'h00FF;
			s2_reg     <= 13'h00FF;
			s3_reg     <= 13'h00FF;
			stable_reg <= 13'h00FF;
		end else begin
			s1_reg     <= raw_in;
			s2_reg     <= s1_reg;
			s3_reg     <= s2_reg;
			stable_reg <= (agree & s3_reg) | (~agree & stable_reg);
		end
	end

	// ************************************************************
	// Decode
	// ************************************************************
	wire [7:0] bus_byte = ~stable_reg[7:0];
	wire       sel_s    = stable_reg[8];
	wire       rd_s     = stable_reg[9];
	wire       wr_s     = stable_reg[10];
	wire       st_s     = stable_reg[11];
	wire       clr_s    = stable_reg[12];
	wire       match    = (bus_byte == DEV_NUM);
	wire [7:0] status   = {dev_specific, dev_busy, dev_examine,
	                       dev_end_of_medium, dev_unavailable};

	logic       latch_reg, latch_next;
	logic       ack_reg, ack_next;
	logic       oe_reg, oe_next;
	logic [7:0] drive_reg, drive_next;
	logic [7:0] wbyte_reg, wbyte_next;
	logic       wpulse_reg, wpulse_next;

	// The ack stays high until all four requests are low, or until system clear drops it.
	wire any_req = sel_s | rd_s | wr_s | st_s;

	always_comb begin
		latch_next  = latch_reg;
		ack_next    = ack_reg;
		oe_next     = oe_reg;
		drive_next  = drive_reg;
		wbyte_next  = wbyte_reg;
		wpulse_next = 1'b0;
		if (clr_s) begin
			latch_next = 1'b0;
			ack_next   = 1'b0;
			oe_next    = 1'b0;
			drive_next = 8'hFF;
		end else if (ack_reg) begin
			if (!any_req) begin
				ack_next = 1'b0;
				oe_next  = 1'b0;
				// Idle level is loaded here so the lines come straight from a register.
				drive_next = 8'hFF;
			end
		end else if (sel_s) begin
			latch_next = match;
			ack_next   = match;
		end else if (latch_reg && rd_s) begin
			drive_next = ~dev_read_byte;
			oe_next    = 1'b1;
			ack_next   = 1'b1;
		end else if (latch_reg && st_s) begin
			drive_next = ~status;
			oe_next    = 1'b1;
			ack_next   = 1'b1;
		end else if (latch_reg && wr_s) begin
			wbyte_next  = bus_byte;
			wpulse_next = 1'b1;
			ack_next    = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_reg  <= 1'b0;
			ack_reg    <= 1'b0;
			oe_reg     <= 1'b0;
			drive_reg  <= 8'hFF;
			wbyte_reg  <= 8'h00;
			wpulse_reg <= 1'b0;
		end else begin
			latch_reg  <= latch_next;
			ack_reg    <= ack_next;
			oe_reg     <= oe_next;
			drive_reg  <= drive_next;
			wbyte_reg  <= wbyte_next;
			wpulse_reg <= wpulse_next;
		end
	end

	assign bus.handshake_ack   = ack_reg;
	assign bus.data_in_oe      = oe_reg;
	assign bus.data_in_lines_n = drive_reg;
	assign dev_write_byte      = wbyte_reg;
	assign dev_write_pulse     = wpulse_reg;
	assign selected            = latch_reg;
endmodule

// file: rtl/iob_chan.sv
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "iob_consts.svh"

module iob_chan #(
	parameter int TIMEOUT_CYC = `IOB_TIMEOUT_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	iob_bus_if.chan          bus,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);
	// ************************************************************
	// Link sampling
	// ************************************************************
	logic [8:0] s1_reg, s2_reg, s3_reg, stable_reg;
	wire  [8:0] raw_in = {bus.handshake_ack, bus.data_in_lines_n};
	wire  [8:0] agree  = ~(s2_reg ^ s3_reg);
	wire        ack_s  = stable_reg[8];
	wire  [7:0] in_byte = ~stable_reg[7:0];

	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WAIT_ACK, ST_WAIT_DROP} iob_st_type;
	iob_st_type state_reg;
	iob_pkg::iob_op_type op_reg;
	logic [31:0] tmo_reg;
	logic [7:0]  dout_reg, result_reg, dev_reg, wdata_reg;
	logic        strobe_reg, clear_reg, busy_reg, timeout_reg;
	logic [1:0]  ist_reg, imask_reg;
	logic        aw_reg, w_reg, bv_reg, rv_reg;
	logic [4:0]  awa_reg;
	logic [31:0] wbuf_reg, rd_reg;
	logic [1:0]  clr_cnt_reg;
	logic        irq_reg;

	wire wr_go   = aw_reg && w_reg && !bv_reg;
	wire ctrl_wr = wr_go && awa_reg == `IOB_REG_CTRL;
	wire rd_go   = s_axi_arvalid && !rv_reg;
	wire done_ev = state_reg == ST_WAIT_DROP && !ack_s;
	wire tmo_ev  = state_reg == ST_WAIT_ACK && tmo_reg == 32'h0;
	wire ist_rd  = rd_go && s_axi_araddr == `IOB_REG_IRQ_STAT;
	wire [2:0] cmd = wbuf_reg[2:0];

	wire [31:0] rd_mux =
		s_axi_araddr == `IOB_REG_DATA     ? {24'h0, wdata_reg} :
		s_axi_araddr == `IOB_REG_STATUS   ? {29'h0, timeout_reg, busy_reg, 1'b0} :
		s_axi_araddr == `IOB_REG_RESULT   ? {24'h0, result_reg} :
		s_axi_araddr == `IOB_REG_IRQ_STAT ? {30'h0, ist_reg} :
		s_axi_araddr == `IOB_REG_IRQ_MASK ? {30'h0, imask_reg} :
		s_axi_araddr == `IOB_REG_CTRL     ? {24'h0, dev_reg} : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= 9'h0FF;
			s2_reg <= 9'h0FF;
			s3_reg <= 9'h0FF;
			stable_reg <= 9'h0FF;
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			stable_reg <= (agree & s3_reg) | (~agree & stable_reg);
		end
	end

	// ************************************************************
	// Register slave
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_reg <= 1'b0;
			w_reg <= 1'b0;
			bv_reg <= 1'b0;
			rv_reg <= 1'b0;
			awa_reg <= 5'h00;
			wbuf_reg <= 32'h0;
			rd_reg <= 32'h0;
			dev_reg <= 8'h00;
			wdata_reg <= 8'h00;
			imask_reg <= 2'h0;
			ist_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_reg && !bv_reg) begin
				aw_reg <= 1'b1;
				awa_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_reg && !bv_reg) begin
				w_reg <= 1'b1;
				wbuf_reg <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_reg <= 1'b0;
				w_reg <= 1'b0;
				bv_reg <= 1'b1;
				if (awa_reg == `IOB_REG_CTRL)
					dev_reg <= wbuf_reg[15:8];
				if (awa_reg == `IOB_REG_DATA)
					wdata_reg <= wbuf_reg[7:0];
				if (awa_reg == `IOB_REG_IRQ_MASK)
					imask_reg <= wbuf_reg[1:0];
			end else if (bv_reg && s_axi_bready) begin
				bv_reg <= 1'b0;
			end
			if (rd_go) begin
				rv_reg <= 1'b1;
				rd_reg <= rd_mux;
			end else if (rv_reg && s_axi_rready) begin
				rv_reg <= 1'b0;
			end
			// Set wins over the clear-on-read.
			ist_reg <= (ist_reg & ~{2{ist_rd}}) | {tmo_ev, done_ev};
			irq_reg <= |(ist_reg & imask_reg);
		end
	end

	// ************************************************************
	// Bus sequencer
	// ************************************************************
	// Control word: bits 2:0 command, bits 15:8 device number.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			op_reg <= iob_pkg::IOB_OP_NONE;
			tmo_reg <= 32'h0;
			dout_reg <= 8'hFF;
			strobe_reg <= 1'b0;
			clear_reg <= 1'b1;
			clr_cnt_reg <= `IOB_CLEAR_CYC;
			busy_reg <= 1'b0;
			timeout_reg <= 1'b0;
			result_reg <= 8'h00;
		end else begin
			// A one-cycle clear would be filtered out by the far end's input stages.
			clear_reg <= clr_cnt_reg != 2'h0;
			if (clr_cnt_reg != 2'h0)
				clr_cnt_reg <= clr_cnt_reg - 2'h1;
			case (state_reg)
				ST_IDLE: begin
					if (ctrl_wr && cmd != 3'h0) begin
						op_reg <= iob_pkg::iob_op_type'(cmd);
						busy_reg <= 1'b1;
						timeout_reg <= 1'b0;
						if (cmd == `IOB_CMD_SELECT)
							dout_reg <= ~wbuf_reg[15:8];
						else if (cmd == `IOB_CMD_WRITE)
							dout_reg <= ~wdata_reg;
						state_reg <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					// Data settles one cycle before the strobe rises.
					strobe_reg <= 1'b1;
					tmo_reg <= TIMEOUT_CYC[31:0];
					state_reg <= ST_WAIT_ACK;
				end
				ST_WAIT_ACK: begin
					tmo_reg <= tmo_reg - 32'h1;
					if (ack_s) begin
						if (op_reg == iob_pkg::IOB_OP_READ || op_reg == iob_pkg::IOB_OP_STATUS)
							result_reg <= in_byte;
						strobe_reg <= 1'b0;
						dout_reg <= 8'hFF;
						state_reg <= ST_WAIT_DROP;
					end else if (tmo_reg == 32'h0) begin
						strobe_reg <= 1'b0;
						dout_reg <= 8'hFF;
						timeout_reg <= 1'b1;
						busy_reg <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				ST_WAIT_DROP: begin
					if (!ack_s) begin
						busy_reg <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign bus.data_out_lines_n = dout_reg;
	assign bus.select_strobe  = strobe_reg && op_reg == iob_pkg::IOB_OP_SELECT;
	assign bus.read_request   = strobe_reg && op_reg == iob_pkg::IOB_OP_READ;
	assign bus.write_strobe   = strobe_reg && op_reg == iob_pkg::IOB_OP_WRITE;
	assign bus.status_request = strobe_reg && op_reg == iob_pkg::IOB_OP_STATUS;
	assign bus.system_clear   = clear_reg;
	assign s_axi_awready = !aw_reg && !bv_reg;
	assign s_axi_wready  = !w_reg && !bv_reg;
	assign s_axi_bvalid  = bv_reg;
	assign s_axi_bresp   = 2'h0;
	assign s_axi_arready = !rv_reg;
	assign s_axi_rvalid  = rv_reg;
	assign s_axi_rdata   = rd_reg;
	assign s_axi_rresp   = 2'h0;
	assign irq = irq_reg;
endmodule

// file: tb/iob_checker.sv
`timescale 1ns/100ps
module iob_checker #(
	parameter logic [7:0] DEV_NUM = 8'h22
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [7:0] data_out_lines_n,
	input wire logic [7:0] data_in_lines_n,
	input wire logic       data_in_oe,
	input wire logic       select_strobe,
	input wire logic       read_request,
	input wire logic       write_strobe,
	input wire logic       status_request,
	input wire logic       handshake_ack
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire any_req = select_strobe | read_request | write_strobe | status_request;
	a_one_request: assert property ($onehot0({select_strobe, read_request, write_strobe,
		status_request})) else $error("two requests at once");
	a_ack_has_cause: assert property ($rose(handshake_ack) |-> any_req) else $error("bad ack");
	a_select_match: assert property ($rose(handshake_ack) && select_strobe |->
		data_out_lines_n == ~DEV_NUM) else $error("ack to wrong number");
	a_idle_lines_high: assert property (!data_in_oe |-> data_in_lines_n == 8'hFF)
		else $error("lines not idle");
	a_drive_cause: assert property ($rose(data_in_oe) |-> read_request || status_request)
		else $error("drive without request");
	a_read_valid: assert property ($rose(handshake_ack) && read_request |-> data_in_oe)
		else $error("read ack without data");
	a_select_release: assert property ($fell(select_strobe) |-> ##[1:20] !handshake_ack)
		else $error("select ack stuck");
	a_read_release: assert property ($fell(read_request) |->
		##[1:20] (!handshake_ack && !data_in_oe)) else $error("read not released");
	a_write_release: assert property ($fell(write_strobe) |-> ##[1:20] !handshake_ack)
		else $error("write ack stuck");
	a_status_release: assert property ($fell(status_request) |->
		##[1:20] (!handshake_ack && !data_in_oe)) else $error("status not released");
	c_write: cover property ($rose(handshake_ack) && write_strobe);
	c_read: cover property ($rose(handshake_ack) && read_request);
	c_status: cover property ($rose(handshake_ack) && status_request);
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq, wpulse, selected;
	logic [4:0]  awaddr, araddr;
	logic [1:0]  bresp, rresp;
	logic [31:0] wdata, rdata, v;
	logic [7:0]  dev_rd, dev_st, wbyte, b;
	logic [63:0] rq[$];
	logic [7:0]  wq[$];
	int          failures, num_checks, i, n;
	iob_bus_if bus();
	iob_chan #(.TIMEOUT_CYC(40)) iob_chan_i (.aclk(aclk), .aresetn(aresetn), .bus(bus),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
	iob_ctrl iob_ctrl_i (.aclk(aclk), .aresetn(aresetn), .bus(bus), .dev_read_byte(dev_rd),
		.dev_busy(dev_st[3]), .dev_examine(dev_st[2]), .dev_end_of_medium(dev_st[1]),
		.dev_unavailable(dev_st[0]), .dev_specific(dev_st[7:4]), .dev_write_byte(wbyte),
		.dev_write_pulse(wpulse), .selected(selected));
	iob_checker iob_checker_i (.aclk(aclk), .aresetn(aresetn),
		.data_out_lines_n(bus.data_out_lines_n), .data_in_lines_n(bus.data_in_lines_n),
		.data_in_oe(bus.data_in_oe), .select_strobe(bus.select_strobe),
		.read_request(bus.read_request), .write_strobe(bus.write_strobe),
		.status_request(bus.status_request), .handshake_ack(bus.handshake_ack));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic finish_test();
		if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tmo();
		failures++;
		finish_test();
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			k++;
		end while (bvalid !== 1'b1 && k < 50);
		bready <= 1'b0;
		if (bvalid !== 1'b1) tmo();
	endtask
	// A mask of zero notes a poll whose data the monitor must not judge.
	task automatic rd(input logic [4:0] a, input logic [31:0] m, e, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rq.push_back({m, e});
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			k++;
		end while (rvalid !== 1'b1 && k < 50);
		r = rdata;
		rready <= 1'b0;
		if (rvalid !== 1'b1) tmo();
	endtask
	task automatic cmd(input logic [31:0] w, output logic [31:0] r);
		int k;
		k = 0;
		wr(5'h00, w);
		do begin
			rd(5'h10, 32'h0, 32'h0, r);
			k++;
		end while (r[1:0] === 2'b00 && k < 100);
		if (r[1:0] === 2'b00) tmo();
	endtask
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready && rq.size() > 0) begin
			if (rq[0][63:32] != 0) chk("rdata", rq[0][31:0] & rq[0][63:32], rdata & rq[0][63:32]);
			void'(rq.pop_front());
		end
		if (wpulse === 1'b1) chk("wbyte", wq.size() > 0 ? wq.pop_front() : 8'hXX, wbyte);
		if (rvalid === 1'b1 && rready) chk("rresp", 32'h0, rresp);
		if (bvalid === 1'b1 && bready) chk("bresp", 32'h0, bresp);
	end
	initial begin
		void'($urandom(32'h18AFB93E));
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, dev_rd, dev_st} = '0;
		failures = 0;
		num_checks = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(5'h18, 32'hFFFFFFFF, 32'h0, v);
		wr(5'h14, 32'h3);
		rd(5'h14, 32'h3, 32'h3, v);
		cmd(32'h2201, v);
		chk("select", 32'h1, v & 32'h3);
		chk("latch", 32'h1, selected);
		for (i = 0; i < 4; i++) begin
			b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			dev_rd <= ~b;
			dev_st <= 8'h00;
			wr(5'h04, {24'h0, b});
			wq.push_back(b);
			cmd(32'h2203, v);
			chk("write", 32'h1, v & 32'h3);
			cmd(32'h2202, v);
			rd(5'h0C, 32'hFF, {24'h0, ~b}, v);
			dev_st <= (i == 1) ? 8'hFF : 8'($urandom);
			cmd(32'h2204, v);
			rd(5'h0C, 32'hFF, {24'h0, dev_st}, v);
		end
		wr(5'h14, 32'h2);
		wr(5'h00, 32'h2301);
		n = 0;
		while (irq !== 1'b1 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		chk("irq", 32'h1, irq);
		if (irq !== 1'b1) tmo();
		rd(5'h10, 32'h2, 32'h2, v);
		repeat (2) @(posedge aclk);
		chk("irq", 32'h0, irq);
		chk("latch", 32'h0, selected);
		cmd(32'h2202, v);
		chk("unselected", 32'h2, v & 32'h2);
		rd(5'h08, 32'h4, 32'h4, v);
		cmd(32'h2201, v);
		chk("latch", 32'h1, selected);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("latch", 32'h0, selected);
		finish_test();
	end
endmodule
